// ### verilog/pcrc_map.svh
`ifndef PCRC_MAP_SVH
`define PCRC_MAP_SVH
`define PCRC_OFS_CTRL 4'h0
`define PCRC_OFS_TAPS 4'h4
`define PCRC_OFS_DATA 4'h8
`define PCRC_OFS_SEED 4'hc
`define PCRC_HALT_BIT 13
`define PCRC_FULL_BIT 7
`define PCRC_EMPTY_BIT 6
`define PCRC_GO_BIT 4
`define PCRC_DEPTH_BIG 5'h10
`define PCRC_DEPTH_SMALL 5'h08
`define PCRC_PLEN_SPLIT 4'h7
`define PCRC_FIFO_W 16
`define PCRC_FIFO_D 16
`define PCRC_TAP_RST 16'h0000
`define PCRC_CRC_RST 16'h0000
`define PCRC_PLEN_RST 4'h0
`endif

// ### verilog/pcrc_pkg.sv
package pcrc_pkg;
  typedef enum logic [1:0] {
    PCRC_IDLE = 2'b01,
    PCRC_SHIFT = 2'b10
  } pcrc_state_t;
  typedef struct packed {
    logic halt;
    logic go;
    logic [3:0] plen;
  } pcrc_ctl_t;
  typedef struct packed {
    logic act;
    logic wr;
    logic [3:0] be;
    logic [3:0] ofs;
  } pcrc_acc_t;
endpackage

// ### verilog/pcrc_top.sv
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pcrc_map.svh"

module pcrc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] lvl_ff;
  logic do_wr;
  logic do_rd;
  assign o_in_ready = (lvl_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (lvl_ff != '0);
  assign o_out_data = mem_ff[rp_ff];
  assign do_wr = i_in_valid & o_in_ready;
  assign do_rd = i_out_ready & o_out_valid;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      lvl_ff <= '0;
    end
    else if (i_flush)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      lvl_ff <= '0;
    end
    else
    begin
      if (do_wr)
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      if (do_rd)
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      lvl_ff <= lvl_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // storage carries no reset; contents are only read while level is nonzero
  genvar e;
  for (e = 0; e < DEPTH; e++)
  begin : g_ent
    always_ff @(posedge i_clk)
    begin
      if (do_wr && wp_ff == AW'(e))
        mem_ff[e] <= i_in_data;
    end
  end
endmodule

module pcrc_top
  import pcrc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_sleep,
  input wire logic i_idle,
  output logic o_crc_irq
);
  pcrc_ctl_t ctl_ff;
  pcrc_acc_t acc_ff;
  pcrc_acc_t nxt_acc;
  pcrc_state_t state_ff;
  pcrc_state_t nxt_state;
  logic [15:0] tap_ff;
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic [15:0] sh_ff;
  logic [15:0] nxt_sh;
  logic [15:0] hold_ff;
  logic [4:0] bits_ff;
  logic [4:0] nxt_bits;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic active_ff;
  logic nxt_active;
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;

  // address phase decode
  wire take = i_hsel & i_htrans[1] & i_hready;
  wire [1:0] lo = i_haddr[1:0];
  wire [3:0] be_byte = 4'h1 << lo;
  wire [3:0] be_half = lo[1] ? 4'hc : 4'h3;
  wire [3:0] be_sel = (i_hsize == 3'h0) ? be_byte :
                      (i_hsize == 3'h1) ? be_half : 4'hf;
  wire [3:0] ofs = {i_haddr[3:2], 2'b00};
  wire mapped = (i_haddr[31:4] == 28'h0000000);

  // data phase write strobes
  wire wr_go = acc_ff.act & acc_ff.wr;
  wire wr_ctrl = wr_go & (acc_ff.ofs == `PCRC_OFS_CTRL);
  wire wr_taps = wr_go & (acc_ff.ofs == `PCRC_OFS_TAPS);
  wire wr_data = wr_go & (acc_ff.ofs == `PCRC_OFS_DATA);
  wire wr_seed = wr_go & (acc_ff.ofs == `PCRC_OFS_SEED);

  // fifo capacity follows the word width
  wire [4:0] cap = (ctl_ff.plen > `PCRC_PLEN_SPLIT) ? `PCRC_DEPTH_SMALL : `PCRC_DEPTH_BIG;
  wire full_now = (cnt_ff == cap);
  wire empty_now = (cnt_ff == 5'h00);

  // a word is complete when its top byte lane is written
  wire top_lane = ctl_ff.plen[3] ? acc_ff.be[1] : acc_ff.be[0];
  wire [15:0] merged = {acc_ff.be[1] ? i_hwdata[15:8] : hold_ff[15:8],
                        acc_ff.be[0] ? i_hwdata[7:0] : hold_ff[7:0]};
  wire word_in = wr_data & top_lane;
  wire roll = word_in & full_now;
  logic fifo_rdy;
  logic fifo_vld;
  logic [15:0] fifo_q;
  wire push = word_in & ~full_now & fifo_rdy;

  // freeze covers sleep and idle with halt set
  wire freeze = i_sleep | (i_idle & ctl_ff.halt);
  wire run = active_ff & ~freeze & ~roll;
  wire shifting = run & (state_ff == PCRC_SHIFT) & (cnt_ff != 5'h00);
  wire word_done = shifting & (bits_ff == 5'h01);
  wire can_load = (state_ff == PCRC_IDLE) | word_done;
  wire load = run & can_load & fifo_vld;

  // lfsr step, one bit per clock
  wire [15:0] taps = {tap_ff[15:1], 1'b1};
  wire fb = crc_ff[ctl_ff.plen] ^ sh_ff[ctl_ff.plen];
  logic [15:0] crc_step;
  genvar g;
  for (g = 0; g < 16; g++)
  begin : g_lfsr
    if (g == 0)
    begin : g_b0
      assign crc_step[g] = fb;
    end
    else
    begin : g_bn
      assign crc_step[g] = (4'(g) > ctl_ff.plen) ? 1'b0 :
                           (crc_ff[g-1] ^ (taps[g] & fb));
    end
  end

  pcrc_fifo #(
    .WIDTH(`PCRC_FIFO_W),
    .DEPTH(`PCRC_FIFO_D)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_flush(roll),
    .i_in_valid(push),
    .o_in_ready(fifo_rdy),
    .i_in_data(merged),
    .o_out_valid(fifo_vld),
    .i_out_ready(load),
    .o_out_data(fifo_q)
  );

  wire dec = word_done;
  wire inc = push;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (roll)
      nxt_cnt = 5'h00;
    else
      nxt_cnt = cnt_ff + 5'(inc) - 5'(dec);
  end

  // starts on a go write, lingers after go clears until the fifo drains
  always_comb
  begin
    nxt_active = active_ff;
    if (wr_ctrl && acc_ff.be[0] && i_hwdata[`PCRC_GO_BIT])
      nxt_active = 1'b1;
    else if (!ctl_ff.go && empty_now)
      nxt_active = 1'b0;
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_sh = sh_ff;
    nxt_bits = bits_ff;
    nxt_crc = crc_ff;
    if (roll)
    begin
      nxt_state = PCRC_IDLE;
      nxt_bits = 5'h00;
    end
    else
    begin
      if (shifting)
      begin
        nxt_crc = crc_step;
        nxt_sh = {sh_ff[14:0], 1'b0};
        nxt_bits = bits_ff - 5'h01;
      end
      if (load)
      begin
        nxt_state = PCRC_SHIFT;
        nxt_sh = fifo_q;
        nxt_bits = {1'b0, ctl_ff.plen} + 5'h01;
      end
      else if (word_done)
        nxt_state = PCRC_IDLE;
    end
    // a seed write overrides the engine for that cycle
    if (wr_seed)
      nxt_crc = merged;
  end

  // read mux sampled in the address phase
  wire [15:0] ctrl_rd = {2'b00, ctl_ff.halt, cnt_ff, full_now, empty_now,
                         1'b0, ctl_ff.go, ctl_ff.plen};
  wire [15:0] rd16 = (ofs == `PCRC_OFS_CTRL) ? ctrl_rd :
                     (ofs == `PCRC_OFS_TAPS) ? {tap_ff[15:1], 1'b0} :
                     (ofs == `PCRC_OFS_DATA) ? crc_ff :
                     (ofs == `PCRC_OFS_SEED) ? crc_ff : 16'h0000;
  wire [31:0] rd_word = mapped ? {16'h0000, rd16} : 32'h00000000;
  wire rd_take = take & ~i_hwrite;

  always_comb
  begin
    nxt_acc = '0;
    if (take)
    begin
      nxt_acc.act = mapped;
      nxt_acc.wr = i_hwrite;
      nxt_acc.be = be_sel;
      nxt_acc.ofs = ofs;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      acc_ff <= '0;
      rdata_ff <= 32'h00000000;
      ready_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      ready_ff <= 1'b1;
      if (rd_take)
        rdata_ff <= rd_word;
    end
  end

  // status bits are never written by software
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctl_ff <= '{halt: 1'b0, go: 1'b0, plen: `PCRC_PLEN_RST};
      tap_ff <= `PCRC_TAP_RST;
    end
    else
    begin
      if (wr_ctrl && acc_ff.be[0])
      begin
        ctl_ff.go <= i_hwdata[`PCRC_GO_BIT];
        ctl_ff.plen <= i_hwdata[3:0];
      end
      if (wr_ctrl && acc_ff.be[1])
        ctl_ff.halt <= i_hwdata[`PCRC_HALT_BIT];
      if (wr_taps && acc_ff.be[0])
        tap_ff[7:1] <= i_hwdata[7:1];
      if (wr_taps && acc_ff.be[1])
        tap_ff[15:8] <= i_hwdata[15:8];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      hold_ff <= 16'h0000;
    else if (wr_data)
      hold_ff <= merged;
  end

  // count starts at zero so empty reads one out of reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_ff <= 5'h00;
      active_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      active_ff <= nxt_active;
      irq_ff <= dec & ~inc & ~roll & (cnt_ff == 5'h01);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff <= PCRC_IDLE;
      sh_ff <= 16'h0000;
      bits_ff <= 5'h00;
      crc_ff <= `PCRC_CRC_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      bits_ff <= nxt_bits;
      crc_ff <= nxt_crc;
    end
  end

  assign o_hrdata = rdata_ff;
  assign o_hreadyout = ready_ff;
  assign o_hresp = 1'b0;
  assign o_crc_irq = irq_ff;
endmodule

// ### sim/pcrc_assertions.sv
`timescale 1ns/1ps
module pcrc_assertions (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_sleep,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_crc_irq
);
  logic rc_ff;
  logic rt_ff;
  wire logic rd_take = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  wire logic [4:0] cnt = o_hrdata[12:8];
  // capacity follows the length field shown in the same read
  wire logic [4:0] cap = (o_hrdata[3:0] > 4'h7) ? 5'h08 : 5'h10;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rc_ff <= 1'b0;
      rt_ff <= 1'b0;
    end
    else
    begin
      rc_ff <= rd_take && (i_haddr == 32'h0);
      rt_ff <= rd_take && (i_haddr == 32'h4);
    end
  end
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  resp_okay_a: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  ready_hold_a: assert property ($past(i_nrst) |-> o_hreadyout)
    else $error("hreadyout dropped");
  irq_pulse_a: assert property (o_crc_irq |=> !o_crc_irq)
    else $error("irq longer than one cycle");
  irq_sleep_a: assert property (o_crc_irq |-> !$past(i_sleep))
    else $error("irq while frozen");
  tap_bits_a: assert property (rt_ff |-> o_hrdata[0] == 1'b0 && o_hrdata[31:16] == 16'h0)
    else $error("tap read bad bits");
  full_flag_a: assert property (rc_ff |-> o_hrdata[7] == (cnt == cap))
    else $error("full flag wrong");
  empty_flag_a: assert property (rc_ff |-> o_hrdata[6] == (cnt == 5'h0))
    else $error("empty flag wrong");
  count_cap_a: assert property (rc_ff |-> cnt <= cap)
    else $error("count above capacity");
  status_rsvd_a: assert property (rc_ff |-> o_hrdata[31:14] == 18'h0 && !o_hrdata[5])
    else $error("control reserved bits set");
endmodule
bind pcrc_top pcrc_assertions u_chk (.i_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
  .i_hready, .i_sleep, .o_hrdata, .o_hreadyout, .o_hresp, .o_crc_irq);

// ### sim/pcrc_top_tb.sv
`timescale 1ns/1ps
`include "pcrc_map.svh"
module pcrc_top_tb
  import pcrc_pkg::*;
;
  logic i_clk = 0, i_nrst = 0, i_hsel = 0, i_hwrite = 0, i_sleep = 0, i_idle = 0, rd_ph = 0;
  logic [31:0] i_haddr = 0, i_hwdata = 0;
  logic [1:0] i_htrans = 0;
  logic [2:0] i_hsize = 0;
  wire logic [31:0] o_hrdata;
  wire logic o_hreadyout, o_hresp, o_crc_irq;
  int mismatches = 0, checked = 0, irqs = 0, n;
  logic [31:0] exq[$];
  logic [15:0] crc_m, d;
  pcrc_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hready(o_hreadyout),
    .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_sleep(i_sleep), .i_idle(i_idle), .o_crc_irq(o_crc_irq));
  initial forever #25 i_clk = ~i_clk;
  task give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // waits rely on the watchdog, the slave never stretches
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] v, input logic [2:0] sz);
    @(posedge i_clk);
    i_hsel <= 1; i_htrans <= 2'h2; i_haddr <= a; i_hwrite <= w; i_hsize <= sz;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0; i_hsel <= 0; i_hwdata <= v; rd_ph <= !w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd_ph <= 0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] v);
    xfer(a, 1'b1, v, 3'h2);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    exq.push_back(e);
    xfer(a, 1'b0, 32'h0, 3'h2);
  endtask
  task wirq(output int c);
    c = 0;
    do begin @(posedge i_clk); c++; end while (o_crc_irq !== 1'b1 && c < 60);
  endtask
  function automatic logic [15:0] crc_f(logic [15:0] c, logic [15:0] tp, logic [3:0] pl,
    logic [15:0] dw);
    logic [15:0] nx;
    logic fb;
    for (int i = 15; i >= 0; i--)
      if (i <= pl)
      begin
        fb = c[pl] ^ dw[i];
        nx = 16'h0;
        nx[0] = fb;
        for (int j = 1; j < 16; j++) if (j <= pl) nx[j] = c[j-1] ^ (tp[j] & fb);
        c = nx;
      end
    return c;
  endfunction
  always @(posedge i_clk) if (rd_ph) chk(o_hrdata, exq.pop_front());
  always @(posedge i_clk) if (o_crc_irq === 1'b1) irqs++;
  initial
  begin
    #250000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    n = $urandom(32'h73a71761);
    repeat (12) @(posedge i_clk);
    i_nrst <= 1;
    repeat (2) @(posedge i_clk);
    rd(`PCRC_OFS_CTRL, 32'h40);
    rd(32'h40, 32'h0);
    wr(`PCRC_OFS_TAPS, 32'hffff);
    rd(`PCRC_OFS_TAPS, 32'hfffe);
    $display("test 1 done");
    d = $urandom;
    crc_m = $urandom;
    wr(`PCRC_OFS_TAPS, 32'h1020);
    wr(`PCRC_OFS_CTRL, 32'hf);
    wr(`PCRC_OFS_SEED, {16'h0, crc_m});
    rd(`PCRC_OFS_SEED, {16'h0, crc_m});
    rd(`PCRC_OFS_CTRL, 32'h4f);
    wr(`PCRC_OFS_DATA, {16'h0, d});
    rd(`PCRC_OFS_CTRL, 32'h10f);
    wr(`PCRC_OFS_CTRL, 32'h1f);
    wirq(n);
    crc_m = crc_f(crc_m, 16'h1020, 4'hf, d);
    rd(`PCRC_OFS_DATA, {16'h0, crc_m});
    rd(`PCRC_OFS_CTRL, 32'h5f);
    d = $urandom;
    wr(`PCRC_OFS_DATA, {16'h0, d});
    wirq(n);
    chk(n, 32'd18);
    crc_m = crc_f(crc_m, 16'h1020, 4'hf, d);
    rd(`PCRC_OFS_DATA, {16'h0, crc_m});
    $display("test 2 done");
    for (int k = 7; k <= 8; k++)
    begin
      wr(`PCRC_OFS_CTRL, k);
      for (int i = 0; i < ((k > 7) ? 8 : 16); i++) wr(`PCRC_OFS_DATA, $urandom & 32'hff);
      rd(`PCRC_OFS_CTRL, (((k > 7) ? 8 : 16) << 8) | 32'h80 | k);
      n = irqs;
      wr(`PCRC_OFS_DATA, 32'h0);
      rd(`PCRC_OFS_CTRL, 32'h40 | k);
      chk(irqs, n);
    end
    $display("test 3 done");
    i_sleep <= 1;
    wr(`PCRC_OFS_CTRL, 32'h2013);
    wr(`PCRC_OFS_DATA, $urandom & 32'hf);
    repeat (20) @(posedge i_clk);
    rd(`PCRC_OFS_CTRL, 32'h2113);
    i_sleep <= 0;
    i_idle <= 1;
    repeat (20) @(posedge i_clk);
    rd(`PCRC_OFS_CTRL, 32'h2113);
    wr(`PCRC_OFS_CTRL, 32'h3);
    wirq(n);
    chk(n < 60, 32'h1);
    rd(`PCRC_OFS_CTRL, 32'h43);
    i_idle <= 0;
    $display("test 4 done");
    give_verdict;
  end
endmodule
